// file: design/decc_pkg.sv
// ****************************************
// data nonvolatile access control constants
// ****************************************
package decc_pkg;

    // array geometry
    localparam int ADDR_W = 8;
    localparam int DEPTH = 256;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_UNLOCK = 8'h0C;
    localparam logic [7:0] OFF_PFLAG = 8'h10;

    // control register bit positions
    localparam int CTL_FETCH = 0;
    localparam int CTL_STORE = 1;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_ABORT = 3;
    // done flag position in the peripheral flag register
    localparam int PFLAG_DONE = 7;

    // unlock key bytes, in order
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // values after reset and erased state
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // default cycle counts of the self-timed write
    localparam int ERASE_CYC = 1000;
    localparam int PROG_CYC = 1000;
    // most cycles allowed between unlock steps
    localparam int UNLOCK_GAP = 8;

    // bus response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // write engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ERASE = 3'b010,
        ST_PROG = 3'b100
    } decc_wr_state_t;

    // unlock sequence tracking states
    typedef enum logic [2:0] {
        UL_IDLE = 3'b001,
        UL_FIRST = 3'b010,
        UL_ARMED = 3'b100
    } decc_unlock_t;

    // implemented control bits
    typedef struct packed {
        logic abort;
        logic permit;
        logic store;
        logic fetch;
    } decc_ctl_t;

    // captured write job
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } decc_job_t;

endpackage : decc_pkg

// file: design/decc_array.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// byte array with erase and program strobes
// ****************************************
module decc_array #(
    parameter int ADDR_W = decc_pkg::ADDR_W,
    parameter int DEPTH = decc_pkg::DEPTH
) (
    // clock
    input wire logic aclk,
    // write side
    input wire logic erase_en,
    input wire logic prog_en,
    input wire decc_pkg::decc_job_t job,
    // core read port
    input wire logic [ADDR_W-1:0] core_addr,
    output logic [7:0] core_byte,
    // programmer read port
    input wire logic [ADDR_W-1:0] ext_addr,
    output logic [7:0] ext_byte
);

    // cells are nonvolatile, so no reset
    logic [7:0] mem [DEPTH];

    // erase forces all ones, program stores the byte
    always_ff @(posedge aclk) begin
        if (erase_en) begin
            mem[job.addr] <= decc_pkg::ERASED_BYTE;
        end else if (prog_en) begin
            mem[job.addr] <= job.data;
        end
    end

    // both reads are combinational
    assign core_byte = mem[core_addr];
    assign ext_byte = mem[ext_addr];

endmodule : decc_array

`default_nettype wire

// file: design/decc_ctrl.sv
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - 256 byte array, address 00h to FFh
// - data and address registers hold byte
// - each write erases then programs location
// - internal timer governs write duration
// - protected array reads zero to programmer
// - control upper four bits read zero
// - triggers set only, hardware clears them
// - program permit gates array writes
// - power up clears program permit
// - abort flag set when reset cuts write
// - aborting reset clears data and address
// - done flag set, software clears it
// - unlock port stores nothing, reads zero
// - fetch completes in one cycle
// - data register keeps fetched byte
// - write needs 55h, AAh, then store
// - store refused unless permit already set
// - permit untouched by hardware, write continues
module decc_ctrl #(
    parameter int ERASE_CYCLES = decc_pkg::ERASE_CYC,
    parameter int PROG_CYCLES = decc_pkg::PROG_CYC,
    parameter int GAP_CYCLES = decc_pkg::UNLOCK_GAP
) (
    // clock and power-on reset
    input wire logic aclk,
    input wire logic aresetn,
    // other device resets
    input wire logic external_reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic brownout_reset,
    // write address channel
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external programmer read port
    input wire logic data_protect_setting_n,
    input wire logic [7:0] prog_addr,
    output logic [7:0] prog_data
);

    // ****************************************
    // declarations
    // ****************************************

    // register contents
    logic [7:0] nvm_data;
    logic [7:0] nvm_address;
    decc_pkg::decc_ctl_t ctl;
    logic done_flag;
    // held write address and data
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    // write engine
    decc_pkg::decc_wr_state_t wr_state;
    logic [15:0] wr_cnt;
    decc_pkg::decc_job_t job;
    // unlock tracking
    decc_pkg::decc_unlock_t ul_state;
    logic [7:0] ul_gap;
    // array read results
    logic [7:0] core_byte;
    logic [7:0] ext_byte;
    // decoded events
    logic dev_rst;
    logic wr_fire;
    logic wr_ok;
    logic wr_data;
    logic wr_addr;
    logic wr_ctrl;
    logic wr_unlock;
    logic wr_pflag;
    logic store_go;
    logic erase_en;
    logic prog_en;
    logic wr_done;
    logic [31:0] next_rdata;
    logic next_rok;

    // ****************************************
    // event decode
    // ****************************************

    // any reset other than power-on, all synchronous
    assign dev_rst = !external_reset_pin_n || watchdog_timeout || brownout_reset;

    // register write takes place once both halves are held
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    // only the low byte lane carries register bits
    assign wr_ok = wr_fire && w_lane;
    assign wr_data = wr_ok && (aw_addr == decc_pkg::OFF_DATA);
    assign wr_addr = wr_ok && (aw_addr == decc_pkg::OFF_ADDR);
    assign wr_ctrl = wr_ok && (aw_addr == decc_pkg::OFF_CTRL);
    assign wr_unlock = wr_ok && (aw_addr == decc_pkg::OFF_UNLOCK);
    assign wr_pflag = wr_ok && (aw_addr == decc_pkg::OFF_PFLAG);

    assign store_go = wr_ctrl && w_byte[decc_pkg::CTL_STORE] && ctl.permit
        && (ul_state == decc_pkg::UL_ARMED) && (wr_state == decc_pkg::ST_IDLE)
        && !dev_rst;

    assign erase_en = (wr_state == decc_pkg::ST_ERASE) && (wr_cnt == 16'(ERASE_CYCLES - 1))
        && !dev_rst;
    assign prog_en = (wr_state == decc_pkg::ST_PROG) && (wr_cnt == 16'(PROG_CYCLES - 1))
        && !dev_rst;
    assign wr_done = prog_en;

    // ****************************************
    // write address and data channels
    // ****************************************

    // address is taken on its own and held until the write fires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            // taken; ready drops so the next waits
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end else begin
            // ready only while nothing is held or answered
            s_axi_awready <= !aw_held && !s_axi_bvalid;
        end
    end

    // data is taken in either order with the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_bvalid;
        end
    end

    // response one cycle after the write fires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= decc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            // unmapped offsets answer with a decode error
            if (aw_addr == decc_pkg::OFF_DATA || aw_addr == decc_pkg::OFF_ADDR
                || aw_addr == decc_pkg::OFF_CTRL || aw_addr == decc_pkg::OFF_UNLOCK
                || aw_addr == decc_pkg::OFF_PFLAG) begin
                s_axi_bresp <= decc_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= decc_pkg::RESP_DECERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // read channels
    // ****************************************

    // read mux, if chain on the offset
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rok = 1'b1;
        if (s_axi_araddr == decc_pkg::OFF_DATA) begin
            next_rdata[7:0] = nvm_data;
        end else if (s_axi_araddr == decc_pkg::OFF_ADDR) begin
            next_rdata[7:0] = nvm_address;
        end else if (s_axi_araddr == decc_pkg::OFF_CTRL) begin
            next_rdata[3:0] = ctl;
        end else if (s_axi_araddr == decc_pkg::OFF_UNLOCK) begin
            next_rdata = 32'h0000_0000;
        end else if (s_axi_araddr == decc_pkg::OFF_PFLAG) begin
            next_rdata[decc_pkg::PFLAG_DONE] = done_flag;
        end else begin
            next_rok = 1'b0;
        end
    end

    // one read at a time, answered the cycle after it is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= decc_pkg::RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rok ? decc_pkg::RESP_OKAY : decc_pkg::RESP_DECERR;
        end else if (s_axi_rvalid) begin
            // drop once the master has it
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // data and address registers
    // ****************************************

    // software write beats a fetch landing in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nvm_data <= decc_pkg::RST_BYTE;
        end else if (dev_rst) begin
            nvm_data <= decc_pkg::RST_BYTE;
        end else if (wr_data) begin
            nvm_data <= w_byte;
        end else if (ctl.fetch) begin
            nvm_data <= core_byte;
        end
    end

    // address register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nvm_address <= decc_pkg::RST_BYTE;
        end else if (dev_rst) begin
            nvm_address <= decc_pkg::RST_BYTE;
        end else if (wr_addr) begin
            nvm_address <= w_byte;
        end
    end

    // ****************************************
    // control register
    // ****************************************

    // fetch trigger lives for exactly one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl.fetch <= 1'b0;
        end else if (dev_rst) begin
            ctl.fetch <= 1'b0;
        end else if (ctl.fetch) begin
            ctl.fetch <= 1'b0;
        end else if (wr_ctrl && w_byte[decc_pkg::CTL_FETCH]) begin
            ctl.fetch <= 1'b1;
        end
    end

    // store trigger mirrors the busy write engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl.store <= 1'b0;
        end else if (dev_rst) begin
            ctl.store <= 1'b0;
        end else if (store_go) begin
            ctl.store <= 1'b1;
        end else if (wr_done) begin
            ctl.store <= 1'b0;
        end
    end

    // permit is software state only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl.permit <= 1'b0;
        end else if (dev_rst) begin
            ctl.permit <= 1'b0;
        end else if (wr_ctrl) begin
            // no hardware clear, running write unaffected
            ctl.permit <= w_byte[decc_pkg::CTL_PERMIT];
        end
    end

    // abort flag survives the reset that sets it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl.abort <= 1'b0;
        end else if (dev_rst && wr_state != decc_pkg::ST_IDLE) begin
            ctl.abort <= 1'b1;
        end else if (wr_ctrl) begin
            // software may clear it after checking
            ctl.abort <= w_byte[decc_pkg::CTL_ABORT];
        end
    end

    // ****************************************
    // done flag
    // ****************************************

    // completion beats a software clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_flag <= 1'b0;
        end else if (wr_done) begin
            done_flag <= 1'b1;
        end else if (dev_rst) begin
            done_flag <= 1'b0;
        end else if (wr_pflag) begin
            done_flag <= w_byte[decc_pkg::PFLAG_DONE];
        end
    end

    // ****************************************
    // unlock sequence tracking
    // ****************************************

    // any foreign write or a long gap breaks the sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ul_state <= decc_pkg::UL_IDLE;
        end else if (dev_rst) begin
            ul_state <= decc_pkg::UL_IDLE;
        end else if (wr_state != decc_pkg::ST_IDLE) begin
            // tracking holds while a write runs
            ul_state <= ul_state;
        end else if (wr_unlock && w_byte == decc_pkg::KEY_FIRST) begin
            ul_state <= decc_pkg::UL_FIRST;
        end else if (wr_unlock && w_byte == decc_pkg::KEY_SECOND
            && ul_state == decc_pkg::UL_FIRST) begin
            ul_state <= decc_pkg::UL_ARMED;
        end else if (wr_ok) begin
            ul_state <= decc_pkg::UL_IDLE;
        end else if (ul_state != decc_pkg::UL_IDLE && ul_gap == 8'(GAP_CYCLES)) begin
            ul_state <= decc_pkg::UL_IDLE;
        end
    end

    // cycles since the last unlock step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ul_gap <= 8'h00;
        end else if (ul_state == decc_pkg::UL_IDLE || wr_ok) begin
            ul_gap <= 8'h00;
        end else if (ul_gap != 8'(GAP_CYCLES)) begin
            ul_gap <= ul_gap + 8'h01;
        end
    end

    // ****************************************
    // self-timed write engine
    // ****************************************

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= decc_pkg::ST_IDLE;
            wr_cnt <= 16'h0000;
        end else if (dev_rst) begin
            // any device reset abandons the cycle
            wr_state <= decc_pkg::ST_IDLE;
            wr_cnt <= 16'h0000;
        end else begin
            case (wr_state)
                decc_pkg::ST_IDLE: begin
                    wr_cnt <= 16'h0000;
                    if (store_go) begin
                        wr_state <= decc_pkg::ST_ERASE;
                    end
                end
                decc_pkg::ST_ERASE: begin
                    if (erase_en) begin
                        wr_state <= decc_pkg::ST_PROG;
                        wr_cnt <= 16'h0000;
                    end else begin
                        wr_cnt <= wr_cnt + 16'h0001;
                    end
                end
                decc_pkg::ST_PROG: begin
                    if (prog_en) begin
                        wr_state <= decc_pkg::ST_IDLE;
                        wr_cnt <= 16'h0000;
                    end else begin
                        wr_cnt <= wr_cnt + 16'h0001;
                    end
                end
                default: begin
                    wr_state <= decc_pkg::ST_IDLE;
                    wr_cnt <= 16'h0000;
                end
            endcase
        end
    end

    // job is frozen so later register writes cannot disturb it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            job <= '0;
        end else if (store_go) begin
            job.addr <= nvm_address;
            job.data <= nvm_data;
        end
    end

    // ****************************************
    // array and programmer port
    // ****************************************

    decc_array #(
        .ADDR_W(decc_pkg::ADDR_W),
        .DEPTH(decc_pkg::DEPTH)
    ) u_array (
        .aclk(aclk),
        .erase_en(erase_en),
        .prog_en(prog_en),
        .job(job),
        .core_addr(nvm_address),
        .core_byte(core_byte),
        .ext_addr(prog_addr),
        .ext_byte(ext_byte)
    );

    // programmer sees zeros while protection is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_data <= decc_pkg::RST_BYTE;
        end else if (!data_protect_setting_n) begin
            prog_data <= decc_pkg::RST_BYTE;
        end else begin
            prog_data <= ext_byte;
        end
    end

endmodule : decc_ctrl

`default_nettype wire

// file: sim/decc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bus and programmer port checker
// ****************************************
module decc_ctrl_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read side
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // programmer port
    input wire logic data_protect_setting_n,
    input wire logic [7:0] prog_data
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    chk_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer not on time");
    chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_prot_zero: assert property (!data_protect_setting_n [*2] |-> prog_data == 8'h00)
        else $error("protected byte visible");
endmodule : decc_ctrl_chk
bind decc_ctrl decc_ctrl_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .data_protect_setting_n, .prog_data);
`default_nettype wire

// file: sim/decc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// core side bus master model
// ****************************************
module decc_core_model (
    // clock
    input wire logic aclk,
    // write channels
    output logic [7:0] awaddr = 8'h00,
    output logic awvalid = 1'b0,
    input wire logic awready,
    output logic [31:0] wdata = 32'h0,
    output logic wvalid = 1'b0,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready = 1'b0,
    // read channels
    output logic [7:0] araddr = 8'h00,
    output logic arvalid = 1'b0,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready = 1'b0
);
    // one write; each half released as it is taken, payload then scrambled
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
        end
        do @(posedge aclk); while (!bvalid);
        // late ready lets the checker see a held answer
        bready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    // one read, data and code taken at the answer edge
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b1;
        @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : decc_core_model
`default_nettype wire

// file: sim/decc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module decc_ctrl_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic external_reset_pin_n = 1'b1;
    logic watchdog_timeout = 1'b0;
    logic brownout_reset = 1'b0;
    logic data_protect_setting_n = 1'b1;
    logic [7:0] prog_addr = 8'h00;
    logic [7:0] prog_data, awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0] rresp, r, bresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int mismatches = 0;
    int n_compared = 0;
    always #25 aclk = ~aclk;
    // short write timing keeps the run brief
    decc_ctrl #(.ERASE_CYCLES(4), .PROG_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn),
        .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout),
        .brownout_reset(brownout_reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .data_protect_setting_n(data_protect_setting_n), .prog_addr(prog_addr), .prog_data(prog_data));
    decc_core_model core (.aclk, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task rc(input logic [7:0] a, input logic [31:0] e);
        core.rd(a, v, r);
        chk(v, e);
    endtask : rc
    task results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    task start;
        core.wr(decc_pkg::OFF_UNLOCK, decc_pkg::KEY_FIRST);
        core.wr(decc_pkg::OFF_UNLOCK, decc_pkg::KEY_SECOND);
        core.wr(decc_pkg::OFF_CTRL, 8'h06);
    endtask : start
    task t_reset;
        rc(decc_pkg::OFF_CTRL, 32'h0);
        rc(decc_pkg::OFF_DATA, 32'h0);
        rc(decc_pkg::OFF_PFLAG, 32'h0);
        core.wr(decc_pkg::OFF_UNLOCK, 8'h12);
        rc(decc_pkg::OFF_UNLOCK, 32'h0);
        core.rd(8'h14, v, r);
        chk({30'h0, r}, {30'h0, decc_pkg::RESP_DECERR});
        core.wr(8'h14, 8'h00);
        chk({30'h0, bresp}, {30'h0, decc_pkg::RESP_DECERR});
        core.wr(decc_pkg::OFF_CTRL, 8'hF3);
        rc(decc_pkg::OFF_CTRL, 32'h0);
        core.wr(decc_pkg::OFF_CTRL, 8'hF4);
        rc(decc_pkg::OFF_CTRL, 32'h4);
    endtask : t_reset
    task t_write;
        int i;
        core.wr(decc_pkg::OFF_ADDR, 8'hFF);
        core.wr(decc_pkg::OFF_DATA, 8'h3C);
        start;
        rc(decc_pkg::OFF_CTRL, 32'h6);
        i = 0;
        do begin
            core.rd(decc_pkg::OFF_CTRL, v, r);
            i++;
        end while (v[1] !== 1'b0 && i < 20);
        chk(v, 32'h4);
        rc(decc_pkg::OFF_PFLAG, 32'h80);
        core.wr(decc_pkg::OFF_PFLAG, 8'h00);
        rc(decc_pkg::OFF_PFLAG, 32'h0);
        core.wr(decc_pkg::OFF_DATA, 8'h00);
        core.wr(decc_pkg::OFF_CTRL, 8'h01);
        rc(decc_pkg::OFF_DATA, 32'h3C);
        rc(decc_pkg::OFF_CTRL, 32'h0);
        prog_addr <= 8'hFF;
        repeat (3) @(posedge aclk);
        chk({24'h0, prog_data}, 32'h3C);
        data_protect_setting_n <= 1'b0;
        repeat (3) @(posedge aclk);
        chk({24'h0, prog_data}, 32'h0);
        data_protect_setting_n <= 1'b1;
    endtask : t_write
    task t_bad_seq;
        core.wr(decc_pkg::OFF_CTRL, 8'h04);
        core.wr(decc_pkg::OFF_UNLOCK, decc_pkg::KEY_FIRST);
        core.wr(decc_pkg::OFF_UNLOCK, 8'h12);
        core.wr(decc_pkg::OFF_UNLOCK, decc_pkg::KEY_SECOND);
        core.wr(decc_pkg::OFF_CTRL, 8'h06);
        rc(decc_pkg::OFF_CTRL, 32'h4);
    endtask : t_bad_seq
    // each device reset cuts a running write short
    task t_abort;
        int k;
        for (k = 0; k < 3; k++) begin
            core.wr(decc_pkg::OFF_CTRL, 8'h04);
            core.wr(decc_pkg::OFF_ADDR, 8'h10);
            core.wr(decc_pkg::OFF_DATA, 8'h5A);
            start;
            @(posedge aclk);
            case (k)
                0: watchdog_timeout <= 1'b1;
                1: brownout_reset <= 1'b1;
                default: external_reset_pin_n <= 1'b0;
            endcase
            @(posedge aclk);
            watchdog_timeout <= 1'b0;
            brownout_reset <= 1'b0;
            external_reset_pin_n <= 1'b1;
            rc(decc_pkg::OFF_CTRL, 32'h8);
            rc(decc_pkg::OFF_DATA, 32'h0);
            rc(decc_pkg::OFF_ADDR, 32'h0);
        end
    endtask : t_abort
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_write;
        t_bad_seq;
        t_abort;
        results;
    end
    // hang guard
    initial begin
        #(20000 * 50);
        mismatches++;
        results;
    end
endmodule : decc_ctrl_test
`default_nettype wire
